// ---- design/closed_loop_consts.vh ----
// What this block does
// - Five-bit code picks closed-loop deceleration rate
// - Deceleration code ignored by closed_loop_decel_rate under speed-mode surge
// - PWM code sets 10 to 75 kHz
// - Phase select gates when speed pulse emits
// - Divider code divides speed pulse output
// - Gating mode stops pulse below threshold
// - Threshold code picks 1 to 30 mV
// - Threshold gain follows bus voltage scale
// - Surge prevention enable bit
// - Dead-time compensation enable bit
// - Bit zero picks recirculation stop action
// - Source select uses acceleration rate instead
`ifndef CLOSED_LOOP_CONSTS_VH
`define CLOSED_LOOP_CONSTS_VH

// ************************************************************
// Register map
// ************************************************************
`define CL_SETTINGS_ONE_OFFSET 8'h88
`define CL_SETTINGS_ONE_RESET 32'h00000000

// ************************************************************
// Field positions
// ************************************************************
`define ACC_MSB 29
`define ACC_LSB 25
`define DEC_SRC_BIT 24
`define DEC_MSB 23
`define DEC_LSB 19
`define PWM_MSB 18
`define PWM_LSB 15
`define PSEL_MSB 13
`define PSEL_LSB 12
`define DIV_MSB 11
`define DIV_LSB 8
`define GATE_BIT 7
`define THR_MSB 6
`define THR_LSB 4
`define SURGE_BIT 3
`define DTC_BIT 2
`define BRAKE_BIT 0

// ************************************************************
// Encodings and timing
// ************************************************************
`define PWM_CODE_MAX 4'hd
`define THR_CODE_MAX 3'h5
`define CLOCK_HZ 50000000
`define PWM_BASE_KHZ 10
`define PWM_STEP_KHZ 5
`define MODE_SPEED 2'h0
`define STOP_RECIRC 3'h1
`define BUS_SCALE_15 2'h0
`define BUS_SCALE_30 2'h1
`define BUS_SCALE_60 2'h2

`endif

// ---- design/pwm_period_lut.v ----
`timescale 1ns/1ps
`include "closed_loop_consts.vh"

// Maps a frequency code to a period in system clocks
module pwm_period_lut (
  input wire [3:0] code,
  output reg [15:0] period,
  output reg valid
);

  wire [15:0] period_tbl [0:13];

  // ************************************************************
  // Period table
  // ************************************************************
  // Division done at elaboration only, so no divider is built in hardware
  genvar k;
  generate
    for (k = 0; k <= `PWM_CODE_MAX; k = k + 1) begin : g_entry
      localparam [31:0] TICKS = `CLOCK_HZ / ((`PWM_BASE_KHZ + `PWM_STEP_KHZ * k) * 1000);
      assign period_tbl[k] = TICKS[15:0];
    end
  endgenerate

  // ************************************************************
  // Period lookup
  // ************************************************************
  // Codes above the top are held at 75 kHz
  // frequency table
  always @* begin
    valid = (code <= `PWM_CODE_MAX);
    if (valid) begin
      period = period_tbl[code];
    end else begin
      period = period_tbl[`PWM_CODE_MAX];
    end
  end

endmodule

// ---- design/bemf_threshold_lut.v ----
`timescale 1ns/1ps
`include "closed_loop_consts.vh"

// Threshold scaled up by the gain to the phase node, in millivolts
module bemf_threshold_lut (
  input wire [2:0] code,
  input wire [1:0] bus_voltage_scale,
  output reg [15:0] thr_node_mv,
  output reg valid
);

  reg [5:0] mv;
  reg [4:0] gain;

  // ************************************************************
  // Threshold and gain
  // ************************************************************
  // threshold table
  always @* begin
    valid = (code <= `THR_CODE_MAX);
    case (code)
      3'h0: mv = 6'h01;
      3'h1: mv = 6'h02;
      3'h2: mv = 6'h05;
      3'h3: mv = 6'h0a;
      3'h4: mv = 6'h14;
      default: mv = 6'h1e;
    endcase
    case (bus_voltage_scale)
      `BUS_SCALE_15: gain = 5'h05;
      `BUS_SCALE_30: gain = 5'h0a;
      default: gain = 5'h14;
    endcase
    // Compare threshold scaled back up to the node voltage in mV
    thr_node_mv = {10'h000, mv} * {11'h000, gain};
  end

endmodule

// ---- design/closed_loop_settings.v ----
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "closed_loop_consts.vh"

// Closed-loop settings register and the logic it steers
module closed_loop_settings #(
  parameter DIV_WIDTH = 4
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  input wire [1:0] control_mode,
  input wire [2:0] stop_option_select,
  input wire [1:0] bus_voltage_scale,
  input wire in_initial_speed_detection,
  input wire in_open_loop,
  input wire in_closed_loop,
  input wire in_align,
  input wire first_attempt,
  input wire motor_driven,
  input wire [15:0] phase_node_mv,
  input wire speed_pulse_in,
  output reg [4:0] closed_loop_decel_rate,
  output reg decel_rate_unlimited,
  output reg [15:0] pwm_period,
  output reg pwm_code_valid,
  output reg speed_pulse_output,
  output reg surge_prevention_enable,
  output reg deadtime_comp_enable,
  output reg stop_low_side_brake,
  output reg stop_hi_z
);

  reg [31:0] cfg_reg;
  reg [DIV_WIDTH-1:0] div_cnt_reg;
  reg div_out_reg;
  reg pulse_prev_reg;
  reg above_thr;
  reg phase_ok;
  reg gate_ok;
  reg [DIV_WIDTH-1:0] div_lim;
  wire [15:0] period_w;
  wire period_ok_w;
  wire [15:0] thr_w;
  wire thr_ok_w;
  wire hit;

  assign hit = (addr == `CL_SETTINGS_ONE_OFFSET);

  // ************************************************************
  // Register access
  // ************************************************************
  // Every bit, reserved ones too, stores and reads back
  // store and read back
  always @(posedge clock) begin
    if (!rst_n) begin
      cfg_reg <= `CL_SETTINGS_ONE_RESET;
      rdata <= 32'h00000000;
    end else begin
      if (wr_en && hit) begin
        cfg_reg <= wdata;
      end
      // Unmapped reads return zero
      if (rd_en) begin
        rdata <= hit ? cfg_reg : 32'h00000000;
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end

  // ************************************************************
  // Lookups
  // ************************************************************
  pwm_period_lut u_pwm (
    .code(cfg_reg[`PWM_MSB:`PWM_LSB]),
    .period(period_w),
    .valid(period_ok_w)
  );

  bemf_threshold_lut u_thr (
    .code(cfg_reg[`THR_MSB:`THR_LSB]),
    .bus_voltage_scale(bus_voltage_scale),
    .thr_node_mv(thr_w),
    .valid(thr_ok_w)
  );

  // ************************************************************
  // Speed pulse qualification
  // ************************************************************
  // Decode phase select, gating mode and divider limit
  always @* begin
    case (cfg_reg[`PSEL_MSB:`PSEL_LSB])
      2'h0: phase_ok = in_initial_speed_detection | in_open_loop | in_closed_loop;
      2'h1: phase_ok = in_closed_loop;
      2'h2: phase_ok = in_open_loop & first_attempt;
      default: phase_ok = 1'b0; // Undefined code stays silent
    endcase
    above_thr = thr_ok_w && (phase_node_mv > thr_w);
    gate_ok = cfg_reg[`GATE_BIT] ? (motor_driven & above_thr) : motor_driven;
    div_lim = (cfg_reg[`DIV_MSB:`DIV_LSB] == 4'h0) ? 4'h1 : cfg_reg[`DIV_MSB:`DIV_LSB];
  end

  // Divide by toggling every div_lim rising edges of the pulse
  // pulse divider
  always @(posedge clock) begin
    if (!rst_n) begin
      div_cnt_reg <= 4'h0;
      div_out_reg <= 1'b0;
      pulse_prev_reg <= 1'b0;
    end else begin
      pulse_prev_reg <= speed_pulse_in;
      if (speed_pulse_in && !pulse_prev_reg) begin
        if (div_cnt_reg + 4'h1 >= div_lim) begin
          div_cnt_reg <= 4'h0;
          div_out_reg <= ~div_out_reg;
        end else begin
          div_cnt_reg <= div_cnt_reg + 4'h1;
        end
      end
    end
  end

  // ************************************************************
  // Steered outputs
  // ************************************************************
  // All outputs registered so downstream sees no decode glitches
  always @(posedge clock) begin
    if (!rst_n) begin
      closed_loop_decel_rate <= 5'h00;
      decel_rate_unlimited <= 1'b0;
      pwm_period <= 16'h0000;
      pwm_code_valid <= 1'b0;
      speed_pulse_output <= 1'b0;
      surge_prevention_enable <= 1'b0;
      deadtime_comp_enable <= 1'b0;
      stop_low_side_brake <= 1'b0;
      stop_hi_z <= 1'b0;
    end else begin
      if (cfg_reg[`DEC_SRC_BIT]) begin
        closed_loop_decel_rate <= cfg_reg[`ACC_MSB:`ACC_LSB];
      end else if (cfg_reg[`SURGE_BIT] && control_mode == `MODE_SPEED) begin
        // Surge logic owns the ramp; report no limit from this field
        closed_loop_decel_rate <= 5'h1f;
      end else begin
        closed_loop_decel_rate <= cfg_reg[`DEC_MSB:`DEC_LSB];
      end
      decel_rate_unlimited <= (cfg_reg[`DEC_SRC_BIT] ?
        cfg_reg[`ACC_MSB:`ACC_LSB] : cfg_reg[`DEC_MSB:`DEC_LSB]) == 5'h1f;
      pwm_period <= period_w;
      pwm_code_valid <= period_ok_w;
      speed_pulse_output <= phase_ok & gate_ok & div_out_reg;
      surge_prevention_enable <= cfg_reg[`SURGE_BIT];
      deadtime_comp_enable <= cfg_reg[`DTC_BIT];
      if (stop_option_select == `STOP_RECIRC && (in_align || in_open_loop)) begin
        stop_low_side_brake <= cfg_reg[`BRAKE_BIT];
        stop_hi_z <= ~cfg_reg[`BRAKE_BIT];
      end else begin
        stop_low_side_brake <= 1'b0;
        stop_hi_z <= 1'b0;
      end
    end
  end

endmodule

// ---- verif/closed_loop_settings_props.sv ----
`timescale 1ns/1ps
// ****************
// Register checker
// ****************
module closed_loop_settings_props (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rdata,
  input wire [1:0] control_mode,
  input wire [2:0] stop_option_select,
  input wire [4:0] closed_loop_decel_rate,
  input wire pwm_code_valid,
  input wire surge_prevention_enable,
  input wire deadtime_comp_enable,
  input wire stop_low_side_brake,
  input wire stop_hi_z
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Write taken, then a quiet cycle so steered outputs settle
  sequence s_wr;
    wr_en && addr == 8'h88 ##1 !(wr_en && addr == 8'h88);
  endsequence
  property p_rd_unmapped;
    rd_en && addr != 8'h88 |=> rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("rd");
  property p_surge;
    s_wr |=> surge_prevention_enable == $past(wdata[3], 2);
  endproperty
  a_surge: assert property (p_surge) else $error("surge");
  property p_dtc;
    s_wr |=> deadtime_comp_enable == $past(wdata[2], 2);
  endproperty
  a_dtc: assert property (p_dtc) else $error("dtc");
  property p_pwm_valid;
    s_wr |=> pwm_code_valid == ($past(wdata[18:15], 2) <= 4'hd);
  endproperty
  a_pwm_valid: assert property (p_pwm_valid) else $error("pwm");
  // Priority between source select and surge is open, so each check excludes the other
  property p_dec_src;
    s_wr |=> !$past(wdata[24], 2) || $past(wdata[3], 2) ||
      closed_loop_decel_rate == $past(wdata[29:25], 2);
  endproperty
  a_dec_src: assert property (p_dec_src) else $error("src");
  property p_dec_surge;
    s_wr |=> !$past(wdata[3], 2) || $past(wdata[24], 2) || $past(control_mode) != 2'h0 ||
      closed_loop_decel_rate == 5'h1f;
  endproperty
  a_dec_surge: assert property (p_dec_surge) else $error("ignore");
  property p_dec_plain;
    s_wr |=> $past(wdata[24], 2) || ($past(wdata[3], 2) && $past(control_mode) == 2'h0) ||
      closed_loop_decel_rate == $past(wdata[23:19], 2);
  endproperty
  a_dec_plain: assert property (p_dec_plain) else $error("dec");
  property p_stop_off;
    (stop_option_select != 3'h1) [*3] |-> !stop_low_side_brake && !stop_hi_z;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop");
endmodule
bind closed_loop_settings closed_loop_settings_props u_props (.*);

// ---- verif/closed_loop_settings_tb.sv ----
`timescale 1ns/1ps
module closed_loop_settings_tb;
  reg clock = 1'h0, rst_n = 1'h0, wr_en = 1'h0, rd_en = 1'h0, speed_pulse_in = 1'h0;
  reg in_initial_speed_detection = 1'h0, in_open_loop = 1'h0, first_attempt = 1'h0;
  reg in_closed_loop = 1'h1, in_align = 1'h0, motor_driven = 1'h1, sp_last = 1'h0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [1:0] control_mode = 2'h0, bus_voltage_scale = 2'h1;
  reg [2:0] stop_option_select = 3'h0;
  reg [15:0] phase_node_mv = 16'h0028;
  wire [31:0] rdata;
  wire [4:0] closed_loop_decel_rate;
  wire [15:0] pwm_period;
  wire decel_rate_unlimited, pwm_code_valid, speed_pulse_output, surge_prevention_enable;
  wire deadtime_comp_enable, stop_low_side_brake, stop_hi_z;
  integer n_mismatch = 0, n_tests = 0, n_edges = 0, i;
  closed_loop_settings uut (.*);
  always #10 clock = ~clock;
  // Count output transitions; !== so an unknown output also counts
  always @(posedge clock) begin
    sp_last <= speed_pulse_output;
    if (speed_pulse_output !== sp_last) n_edges <= n_edges + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Steered outputs land one edge after the write is taken
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'h1;
      @(posedge clock);
      wr_en <= 1'h0;
      repeat (2) @(posedge clock);
      #1;
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clock);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge clock);
      rd_en <= 1'h0;
      // Read data stand only in the cycle after the strobe
      #1;
      chk(rdata, exp);
    end
  endtask
  // Even pulse counts keep the divider phase known between tests
  task pulses(input integer n, input integer exp);
    integer base;
    begin
      base = n_edges;
      repeat (n) begin
        repeat (2) @(posedge clock);
        speed_pulse_in <= 1'h1;
        repeat (2) @(posedge clock);
        speed_pulse_in <= 1'h0;
      end
      repeat (8) @(posedge clock);
      #1;
      chk(n_edges - base, exp);
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    rd(8'h88, 32'h0);
    wr(8'h88, 32'hffffffff);
    rd(8'h88, 32'hffffffff);
    wr(8'h8a, 32'h0);
    rd(8'h8a, 32'h0);
    rd(8'h88, 32'hffffffff);
    $display("register test done");
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'h88, i << 15);
      chk(pwm_period, 50000 / (i > 13 ? 75 : 10 + 5 * i));
      chk(pwm_code_valid, i < 14);
    end
    wr(8'h88, 32'h0e980004);
    chk(closed_loop_decel_rate, 5'h13);
    chk(deadtime_comp_enable, 1'h1);
    wr(8'h88, 32'h0f980000);
    chk(closed_loop_decel_rate, 5'h07);
    wr(8'h88, 32'h00f80000);
    chk(decel_rate_unlimited, 1'h1);
    wr(8'h88, 32'h00980008);
    chk(closed_loop_decel_rate, 5'h1f);
    chk(surge_prevention_enable, 1'h1);
    @(posedge clock) control_mode <= 2'h1;
    wr(8'h88, 32'h00980008);
    chk(closed_loop_decel_rate, 5'h13);
    @(posedge clock) in_align <= 1'h1;
    wr(8'h88, 32'h1);
    chk({stop_low_side_brake, stop_hi_z}, 2'h0);
    @(posedge clock) stop_option_select <= 3'h1;
    wr(8'h88, 32'h1);
    chk({stop_low_side_brake, stop_hi_z}, 2'h2);
    wr(8'h88, 32'h0);
    chk({stop_low_side_brake, stop_hi_z}, 2'h1);
    $display("settings test done");
    wr(8'h88, 32'h300);
    pulses(12, 4);
    wr(8'h88, 32'h0);
    pulses(4, 4);
    wr(8'h88, 32'h3000);
    pulses(4, 0);
    wr(8'h88, 32'h1000);
    pulses(4, 4);
    wr(8'h88, 32'h2000);
    pulses(4, 0);
    @(posedge clock) in_open_loop <= 1'h1;
    first_attempt <= 1'h1;
    pulses(4, 4);
    wr(8'h88, 32'ha0);
    pulses(4, 0);
    @(posedge clock) phase_node_mv <= 16'h003c;
    pulses(4, 4);
    @(posedge clock) bus_voltage_scale <= 2'h2;
    pulses(4, 0);
    // Code 7 has no threshold, so even a large node voltage keeps the pulse off
    wr(8'h88, 32'hf0);
    @(posedge clock) phase_node_mv <= 16'h0400;
    pulses(4, 0);
    $display("pulse test done");
    end_of_test;
  end
  // Whole run is under 500 cycles; this span leaves wide margin
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
endmodule
